// >>> rtl/dsc_bank.sv
`default_nettype none
// per-bank state tracker: row open, precharge timing, auto-precharge at burst end
module dsc_bank
  import dsc_pkg::*;
#(
  parameter int PRE_CYC = DSC_PRE_CYC,
  parameter int BURST_CYC = DSC_BURST_CYC
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // decoded commands for this bank
  input wire logic act_hit,
  input wire logic pre_hit,
  input wire logic acc_hit,
  input wire logic acc_auto_pre,
  input wire logic [DSC_ROW_W-1:0] row_in,
  // state
  output dsc_bank_type state,
  output logic [DSC_ROW_W-1:0] open_row
);
  dsc_bank_type state_ff;
  logic [DSC_ROW_W-1:0] row_ff;
  logic [3:0] cnt_ff;
  logic ap_pending_ff;

  assign state = state_ff;
  assign open_row = row_ff;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_ff <= DSC_BANK_IDLE;
      cnt_ff <= 4'h0;
      ap_pending_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        DSC_BANK_IDLE:
        begin
          if (act_hit)
          begin
            state_ff <= DSC_BANK_OPEN;
          end
        end
        DSC_BANK_OPEN:
        begin
          if (pre_hit)
          begin
            state_ff <= DSC_BANK_PRE;
            cnt_ff <= 4'(PRE_CYC - 1);
            ap_pending_ff <= 1'b0;
          end
          else if (acc_hit && acc_auto_pre)
          begin
            ap_pending_ff <= 1'b1;
            cnt_ff <= 4'(BURST_CYC - 1);
          end
          else if (acc_hit)
          begin
            ap_pending_ff <= 1'b0;
          end
          else if (ap_pending_ff)
          begin
            if (cnt_ff == 4'h0)
            begin
              state_ff <= DSC_BANK_PRE;
              cnt_ff <= 4'(PRE_CYC - 1);
              ap_pending_ff <= 1'b0;
            end
            else
            begin
              cnt_ff <= cnt_ff - 4'h1;
            end
          end
        end
        default:
        begin
          // second precharge here is ignored
          if (cnt_ff == 4'h0)
          begin
            state_ff <= DSC_BANK_IDLE;
          end
          else
          begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      row_ff <= '0;
    end
    else if (state_ff == DSC_BANK_IDLE && act_hit)
    begin
      row_ff <= row_in;
    end
  end

  a_pre_closes: assert property (@(posedge ref_clk) disable iff (rst)
    (state_ff == DSC_BANK_OPEN && pre_hit) |=> state_ff == DSC_BANK_PRE)
    else $error("precharge did not close bank");
  a_idle_pre_nop: assert property (@(posedge ref_clk) disable iff (rst)
    (state_ff == DSC_BANK_IDLE && !act_hit) |=> state_ff == DSC_BANK_IDLE)
    else $error("idle bank changed without activate");
  a_act_opens: assert property (@(posedge ref_clk) disable iff (rst)
    (state_ff == DSC_BANK_IDLE && act_hit) |=> (state_ff == DSC_BANK_OPEN
    && row_ff == $past(row_in)))
    else $error("activate did not open row");
endmodule
`default_nettype wire

// >>> rtl/dsc_core.sv
`default_nettype none
// command decoder, extended config register, refresh and write-mask path
module dsc_core
  import dsc_pkg::*;
#(
  parameter int BANKS = DSC_BANKS,
  parameter int DQ_W = 16,
  parameter int MASK_W = 2,
  parameter int REF_MAX_CYC = DSC_REF_MAX_CYC,
  parameter logic [1:0] ORG = 2'h2
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // command pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic bank_select_low,
  input wire logic bank_select_high,
  input wire logic [DSC_ROW_W-1:0] addr,
  // write data
  input wire logic [DQ_W-1:0] wr_data,
  input wire logic [MASK_W-1:0] write_byte_mask,
  input wire logic wr_data_valid,
  // array side
  output logic array_wr_en,
  output logic [MASK_W-1:0] array_byte_en,
  output logic [DQ_W-1:0] array_wr_data,
  output logic [1:0] array_bank,
  output logic [DSC_COL_W-1:0] array_col,
  output logic refresh_pulse,
  output logic [DSC_RFADDR_W-1:0] refresh_addr,
  // status
  output logic loop_enabled,
  output logic drive_weak,
  output logic self_refresh,
  output logic read_active,
  output logic refresh_late,
  output logic [BANKS-1:0] bank_open
);
  logic [DSC_EMR_W-1:0] extended_mode_config_ff;
  logic self_ref_ff;
  logic read_act_ff;
  logic read_ap_ff;
  logic [3:0] burst_cnt_ff;
  logic [DSC_RFADDR_W-1:0] rf_addr_ff;
  logic [31:0] ref_gap_ff;
  logic [DQ_W-1:0] wdata_ff;
  logic [MASK_W-1:0] ben_ff;
  logic wen_ff;
  logic [1:0] bank_ff;
  logic [DSC_COL_W-1:0] col_ff;
  logic [2:0] cmd;
  logic cmd_ok;
  logic [1:0] bsel;
  logic ap;
  dsc_bank_type bstate [BANKS];

  function automatic logic [DSC_COL_W-1:0] start_col(input logic [DSC_ROW_W-1:0] a,
                                                     input logic [1:0] org);
    logic [DSC_COL_W-1:0] c;
    c = '0;
    if (org == 2'h2)
    begin
      c = {2'h0, a[DSC_COL_HI_X16:0]};
    end
    else if (org == 2'h1)
    begin
      c = {1'h0, a[DSC_COL_HI_X8:0]};
    end
    else
    begin
      c = {a[DSC_COL_X4_EXTRA], a[DSC_COL_HI_X8:0]};
    end
    return c;
  endfunction

  // deselect and no-operation decode as nothing; running bursts keep going
  assign cmd = {ras_n, cas_n, we_n};
  assign cmd_ok = !cs_n && !self_ref_ff && cmd != DSC_CMD_NOP;
  assign bsel = {bank_select_high, bank_select_low};
  assign ap = addr[DSC_AP_BIT];

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      extended_mode_config_ff <= DSC_EMR_RESET;
    end
    else if (cmd_ok && cke && cmd == DSC_CMD_LOAD && bsel == DSC_SEL_EXT)
    begin
      extended_mode_config_ff <= addr;
    end
  end

  // loop forced off in self refresh, restored from the register on exit
  assign loop_enabled = !extended_mode_config_ff[DSC_LOOP_BIT] && !self_ref_ff;
  assign drive_weak = extended_mode_config_ff[DSC_DRIVE_BIT];
  assign self_refresh = self_ref_ff;
  assign read_active = read_act_ff;
  assign refresh_late = ref_gap_ff >= 32'(REF_MAX_CYC);

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      self_ref_ff <= 1'b0;
    end
    else if (self_ref_ff)
    begin
      if (cke)
      begin
        self_ref_ff <= 1'b0;
      end
    end
    else if (cmd_ok && !cke && cmd == DSC_CMD_REF)
    begin
      self_ref_ff <= 1'b1;
    end
  end

  // auto refresh ignores address pins; internal row counter advances
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rf_addr_ff <= '0;
      refresh_pulse <= 1'b0;
    end
    else
    begin
      refresh_pulse <= cmd_ok && cke && cmd == DSC_CMD_REF;
      if (cmd_ok && cke && cmd == DSC_CMD_REF)
      begin
        rf_addr_ff <= rf_addr_ff + DSC_RFADDR_W'(1);
      end
    end
  end
  assign refresh_addr = rf_addr_ff;

  // gap monitor, saturating; flags controller lateness only
  always_ff @(posedge ref_clk)
  begin
    if (rst || (cmd_ok && cmd == DSC_CMD_REF) || self_ref_ff)
    begin
      ref_gap_ff <= '0;
    end
    else if (!refresh_late)
    begin
      ref_gap_ff <= ref_gap_ff + 32'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read burst tracking for terminate
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      read_act_ff <= 1'b0;
      read_ap_ff <= 1'b0;
      burst_cnt_ff <= 4'h0;
    end
    else if (cmd_ok && cmd == DSC_CMD_READ)
    begin
      read_act_ff <= 1'b1;
      read_ap_ff <= ap;
      burst_cnt_ff <= 4'(DSC_BURST_CYC - 1);
    end
    else if (cmd_ok && cmd == DSC_CMD_TERM && read_act_ff && !read_ap_ff)
    begin
      read_act_ff <= 1'b0;
    end
    else if (read_act_ff)
    begin
      if (burst_cnt_ff == 4'h0)
      begin
        read_act_ff <= 1'b0;
      end
      else
      begin
        burst_cnt_ff <= burst_cnt_ff - 4'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // access address latch and masked write path
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      bank_ff <= 2'h0;
      col_ff <= '0;
    end
    else if (cmd_ok && (cmd == DSC_CMD_READ || cmd == DSC_CMD_WRITE))
    begin
      bank_ff <= bsel;
      col_ff <= start_col(addr, ORG);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wen_ff <= 1'b0;
      ben_ff <= '0;
      wdata_ff <= '0;
    end
    else
    begin
      wen_ff <= wr_data_valid && (write_byte_mask != {MASK_W{1'b1}});
      ben_ff <= ~write_byte_mask;
      wdata_ff <= wr_data;
    end
  end
  assign array_wr_en = wen_ff;
  assign array_byte_en = ben_ff;
  assign array_wr_data = wdata_ff;
  assign array_bank = bank_ff;
  assign array_col = col_ff;

  //////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < BANKS; g++)
    begin : g_bank
      dsc_bank u_bank (
        .ref_clk(ref_clk),
        .rst(rst),
        .act_hit(cmd_ok && cmd == DSC_CMD_ACT && bsel == 2'(g)),
        .pre_hit(cmd_ok && cmd == DSC_CMD_PRE && (ap || bsel == 2'(g))),
        .acc_hit(cmd_ok && (cmd == DSC_CMD_READ || cmd == DSC_CMD_WRITE) && bsel == 2'(g)),
        .acc_auto_pre(ap),
        .row_in(addr),
        .state(bstate[g]),
        .open_row()
      );
      assign bank_open[g] = bstate[g] == DSC_BANK_OPEN;
    end
  endgenerate

  a_ext_load: assert property (@(posedge ref_clk) disable iff (rst)
    (cmd_ok && cke && cmd == DSC_CMD_LOAD && bsel == DSC_SEL_EXT)
    |=> extended_mode_config_ff == $past(addr))
    else $error("extended config not loaded");
  a_base_no_load: assert property (@(posedge ref_clk) disable iff (rst)
    (cmd_ok && cmd == DSC_CMD_LOAD && bsel == DSC_SEL_BASE)
    |=> $stable(extended_mode_config_ff))
    else $error("base load touched extended config");
  a_loop_ctrl: assert property (@(posedge ref_clk) disable iff (rst)
    (cmd_ok && cke && cmd == DSC_CMD_LOAD && bsel == DSC_SEL_EXT)
    |=> loop_enabled == !$past(addr[DSC_LOOP_BIT]))
    else $error("loop enable does not follow config");
  a_drive_sel: assert property (@(posedge ref_clk) disable iff (rst)
    (cmd_ok && cke && cmd == DSC_CMD_LOAD && bsel == DSC_SEL_EXT)
    |=> drive_weak == $past(addr[DSC_DRIVE_BIT]))
    else $error("drive strength does not follow config");
  a_sr_loop_off: assert property (@(posedge ref_clk) disable iff (rst)
    (cmd_ok && !cke && cmd == DSC_CMD_REF) |=> (self_ref_ff && !loop_enabled))
    else $error("self refresh did not stop loop");
  a_nop_keeps: assert property (@(posedge ref_clk) disable iff (rst)
    (cs_n && !self_ref_ff) |=> ($stable(extended_mode_config_ff) && $stable(rf_addr_ff)))
    else $error("deselect changed state");
  a_term_cuts: assert property (@(posedge ref_clk) disable iff (rst)
    (cmd_ok && cmd == DSC_CMD_TERM && read_act_ff && !read_ap_ff) |=> !read_act_ff)
    else $error("terminate did not cut read");
  a_refresh_adv: assert property (@(posedge ref_clk) disable iff (rst)
    (cmd_ok && cke && cmd == DSC_CMD_REF) |=> (refresh_pulse
    && rf_addr_ff == $past(rf_addr_ff) + DSC_RFADDR_W'(1)))
    else $error("refresh counter did not advance");
  a_mask_write: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_data_valid && write_byte_mask == {MASK_W{1'b1}}) |=> !array_wr_en)
    else $error("fully masked write reached array");
endmodule
`default_nettype wire

// >>> rtl/dsc_pkg.sv
`default_nettype none
package dsc_pkg;
  localparam int DSC_BANKS = 4;
  localparam int DSC_ROW_W = 13;
  localparam int DSC_EMR_W = 13;
  localparam logic [1:0] DSC_SEL_BASE = 2'h0;
  localparam logic [1:0] DSC_SEL_EXT = 2'h1;
  localparam int DSC_LOOP_BIT = 0;
  localparam int DSC_DRIVE_BIT = 1;
  localparam int DSC_AP_BIT = 10;
  localparam int DSC_COL_HI_X16 = 8;
  localparam int DSC_COL_HI_X8 = 9;
  localparam int DSC_COL_X4_EXTRA = 11;
  localparam int DSC_COL_W = 11;
  localparam logic [DSC_EMR_W-1:0] DSC_EMR_RESET = 13'h0000;
  // command codes: {ras_n, cas_n, we_n}
  localparam logic [2:0] DSC_CMD_NOP = 3'h7;
  localparam logic [2:0] DSC_CMD_ACT = 3'h3;
  localparam logic [2:0] DSC_CMD_READ = 3'h5;
  localparam logic [2:0] DSC_CMD_WRITE = 3'h4;
  localparam logic [2:0] DSC_CMD_TERM = 3'h6;
  localparam logic [2:0] DSC_CMD_PRE = 3'h2;
  localparam logic [2:0] DSC_CMD_REF = 3'h1;
  localparam logic [2:0] DSC_CMD_LOAD = 3'h0;
  localparam real DSC_CLK_MHZ = 125.0;
  localparam real DSC_REFI_US = 7.8;
  localparam real DSC_REF_MAX_US = 70.2;
  localparam int DSC_REF_MAX_CYC = int'($floor(DSC_REF_MAX_US * DSC_CLK_MHZ));
  localparam int DSC_REFI_CYC = int'($floor(DSC_REFI_US * DSC_CLK_MHZ));
  localparam int DSC_PRE_CYC = 3;
  localparam int DSC_BURST_CYC = 4;
  localparam int DSC_RFADDR_W = 15;
  typedef enum logic [1:0]
  {
    DSC_BANK_IDLE = 2'h0,
    DSC_BANK_OPEN = 2'h1,
    DSC_BANK_PRE = 2'h2
  } dsc_bank_type;
endpackage
`default_nettype wire

// >>> sim/dsc_ctrl_model.sv
`default_nettype none
// memory controller stand-in: drives one command per call, released lines show the inverse
module dsc_ctrl_model
  import dsc_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // command pins toward the device
  output var logic cke,
  output var logic cs_n,
  output var logic ras_n,
  output var logic cas_n,
  output var logic we_n,
  output var logic bank_select_low,
  output var logic bank_select_high,
  output var logic [DSC_ROW_W-1:0] addr
);
  timeunit 1ns;
  timeprecision 100ps;
  ////////////////////////////////////////
  initial
  begin
    cke = 1'b1;
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = DSC_CMD_NOP;
    {bank_select_high, bank_select_low} = 2'h0;
    addr = 13'h0000;
  end
  // caller stands just after an edge; the command is held through the next sampling edge
  task automatic issue(input logic sel_n, input logic [2:0] code, input logic [1:0] bank,
                       input logic [DSC_ROW_W-1:0] a, input logic ck);
    cke = ck;
    cs_n = sel_n;
    {ras_n, cas_n, we_n} = code;
    {bank_select_high, bank_select_low} = bank;
    addr = a;
    @(posedge ref_clk);
    #1;
  endtask
  // deselect: inverted leftovers so a device that ignores cs_n would misbehave visibly
  task automatic release_bus();
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = ~{ras_n, cas_n, we_n};
    {bank_select_high, bank_select_low} = ~{bank_select_high, bank_select_low};
    addr = ~addr;
  endtask
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
`default_nettype none
module tb_top
  import dsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cke, cs_n, ras_n, cas_n, we_n, bank_select_low, bank_select_high;
  logic [DSC_ROW_W-1:0] addr;
  logic [15:0] wr_data = 16'h0000;
  logic [1:0] write_byte_mask = 2'h0;
  logic wr_data_valid = 1'b0;
  logic array_wr_en, refresh_pulse, loop_enabled, drive_weak;
  logic self_refresh, read_active, refresh_late;
  logic [1:0] array_byte_en, array_bank;
  logic [15:0] array_wr_data;
  logic [DSC_COL_W-1:0] array_col;
  logic [DSC_RFADDR_W-1:0] refresh_addr;
  logic [3:0] bank_open;
  logic [17:0] wq[$];
  logic rq[$];
  logic [DSC_COL_W-1:0] col_x8, col_x4;
  logic [15:0] rnd = 16'h0054;
  int fail_count = 0;
  int checked = 0;
  ////////////////////////////////////////
  initial
  begin
    forever #4 ref_clk = ~ref_clk;
  end
  dsc_ctrl_model ctl (.ref_clk(ref_clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .bank_select_low(bank_select_low), .bank_select_high(bank_select_high),
    .addr(addr));
  dsc_core #(.REF_MAX_CYC(100)) DUT (.ref_clk(ref_clk), .rst(rst), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_select_low(bank_select_low),
    .bank_select_high(bank_select_high), .addr(addr), .wr_data(wr_data),
    .write_byte_mask(write_byte_mask), .wr_data_valid(wr_data_valid),
    .array_wr_en(array_wr_en), .array_byte_en(array_byte_en), .array_wr_data(array_wr_data),
    .array_bank(array_bank), .array_col(array_col), .refresh_pulse(refresh_pulse),
    .refresh_addr(refresh_addr), .loop_enabled(loop_enabled), .drive_weak(drive_weak),
    .self_refresh(self_refresh), .read_active(read_active), .refresh_late(refresh_late),
    .bank_open(bank_open));
  // narrower organisations only feed the column checks
  dsc_core #(.REF_MAX_CYC(100), .ORG(2'h1)) DUT_X8 (.ref_clk(ref_clk), .rst(rst), .cke(cke),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_select_low(bank_select_low),
    .bank_select_high(bank_select_high), .addr(addr), .wr_data(wr_data),
    .write_byte_mask(write_byte_mask), .wr_data_valid(wr_data_valid), .array_wr_en(),
    .array_byte_en(), .array_wr_data(), .array_bank(), .array_col(col_x8), .refresh_pulse(),
    .refresh_addr(), .loop_enabled(), .drive_weak(), .self_refresh(), .read_active(),
    .refresh_late(), .bank_open());
  dsc_core #(.REF_MAX_CYC(100), .ORG(2'h0)) DUT_X4 (.ref_clk(ref_clk), .rst(rst), .cke(cke),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_select_low(bank_select_low),
    .bank_select_high(bank_select_high), .addr(addr), .wr_data(wr_data),
    .write_byte_mask(write_byte_mask), .wr_data_valid(wr_data_valid), .array_wr_en(),
    .array_byte_en(), .array_wr_data(), .array_bank(), .array_col(col_x4), .refresh_pulse(),
    .refresh_addr(), .loop_enabled(), .drive_weak(), .self_refresh(), .read_active(),
    .refresh_late(), .bank_open());
  ////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic step(input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      #1;
    end
  endtask
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // one deselect cycle after each command keeps pin changes one per time step
  task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [12:0] x, input logic k);
    ctl.issue(1'b0, c, b, x, k);
    ctl.release_bus();
    step(1);
  endtask
  task automatic burst();
    for (int k = 0; k < 4; k++)
    begin
      rnd = lfsr(rnd);
      wr_data = rnd;
      write_byte_mask = k[1:0];
      wr_data_valid = 1'b1;
      if (k != 3)
        wq.push_back({~k[1:0], rnd});
      step(1);
    end
    wr_data_valid = 1'b0;
  endtask
  task automatic wait_closed(input int b);
    int n;
    n = 0;
    while (bank_open[b] !== 1'b0 && n < 16)
    begin
      step(1);
      n++;
    end
    check("bank closed", 0, bank_open[b]);
    if (n >= 16)
      print_verdict();
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////
  always @(negedge ref_clk)
  begin
    if (array_wr_en === 1'b1)
      check("array write", wq.size() > 0 ? {14'h0, wq.pop_front()} : 32'hFFFFFFFF,
            {array_byte_en, array_wr_data});
    if (refresh_pulse === 1'b1)
      check("refresh", rq.size() > 0 ? rq.pop_front() : 1'b0, 1);
  end
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    print_verdict();
  end
  initial
  begin
    step(8);
    rst = 1'b0;
    check("loop", 1, loop_enabled);
    check("drive", 0, drive_weak);
    check("banks", 0, bank_open);
    for (int i = 0; i < 4; i++)
    begin
      cmd(DSC_CMD_LOAD, DSC_SEL_EXT, 13'(i), 1'b1);
      check("loop", !i[0], loop_enabled);
      check("drive", i[1], drive_weak);
      rnd = lfsr(rnd);
      step(2);
      cmd(DSC_CMD_LOAD, DSC_SEL_BASE, rnd[12:0] & 13'h007F, 1'b1);
      check("drive held", i[1], drive_weak);
      step(2);
    end
    cmd(DSC_CMD_LOAD, DSC_SEL_EXT, 13'h0000, 1'b1);
    check("loop", 1, loop_enabled);
    step(200);
    ctl.issue(1'b1, DSC_CMD_ACT, 2'h1, 13'h0ABC, 1'b1);
    ctl.release_bus();
    step(1);
    cmd(DSC_CMD_NOP, 2'h2, 13'h1234, 1'b1);
    check("banks", 0, bank_open);
    for (int b = 0; b < 4; b++)
    begin
      rnd = lfsr(rnd);
      cmd(DSC_CMD_ACT, b[1:0], rnd[12:0], 1'b1);
      check("bank open", 1, bank_open[b]);
    end
    cmd(DSC_CMD_PRE, 2'h1, 13'h0000, 1'b1);
    check("banks", 4'hD, bank_open);
    cmd(DSC_CMD_PRE, 2'h1, 13'h0000, 1'b1);
    check("banks", 4'hD, bank_open);
    rnd = lfsr(rnd);
    cmd(DSC_CMD_PRE, rnd[1:0], 13'h0400, 1'b1);
    check("banks", 0, bank_open);
    step(DSC_PRE_CYC);
    cmd(DSC_CMD_ACT, 2'h0, 13'h0111, 1'b1);
    cmd(DSC_CMD_ACT, 2'h2, 13'h0222, 1'b1);
    rnd = lfsr(rnd);
    ctl.issue(1'b0, DSC_CMD_WRITE, 2'h0, rnd[12:0] | 13'h0400, 1'b1);
    check("col", {2'h0, rnd[8:0]}, array_col);
    check("col x8", {1'h0, rnd[9:0]}, col_x8);
    check("col x4", {rnd[11], rnd[9:0]}, col_x4);
    check("bank", 0, array_bank);
    ctl.release_bus();
    burst();
    wait_closed(0);
    check("banks", 4'h4, bank_open);
    step(DSC_PRE_CYC);
    ctl.issue(1'b0, DSC_CMD_WRITE, 2'h2, 13'h0005, 1'b1);
    ctl.release_bus();
    burst();
    step(6);
    check("banks", 4'h4, bank_open);
    ctl.issue(1'b0, DSC_CMD_READ, 2'h2, 13'h0008, 1'b1);
    ctl.issue(1'b0, DSC_CMD_TERM, 2'h0, 13'h0000, 1'b1);
    ctl.release_bus();
    step(1);
    check("reading", 0, read_active);
    step(4);
    ctl.issue(1'b0, DSC_CMD_READ, 2'h2, 13'h0400, 1'b1);
    ctl.issue(1'b0, DSC_CMD_TERM, 2'h0, 13'h0000, 1'b1);
    ctl.release_bus();
    step(1);
    check("reading", 1, read_active);
    wait_closed(2);
    step(DSC_PRE_CYC);
    rnd = lfsr(rnd);
    rq.push_back(1'b1);
    cmd(DSC_CMD_REF, 2'h3, rnd[12:0], 1'b1);
    check("refresh addr", 1, refresh_addr);
    step(50);
    check("late", 0, refresh_late);
    step(60);
    check("late", 1, refresh_late);
    rq.push_back(1'b1);
    cmd(DSC_CMD_REF, 2'h0, 13'h0000, 1'b1);
    check("late", 0, refresh_late);
    check("refresh addr", 2, refresh_addr);
    // self refresh entry is not an auto refresh: no pulse, no counter step
    cmd(DSC_CMD_REF, 2'h0, 13'h0000, 1'b0);
    check("self refresh", 1, self_refresh);
    check("refresh addr", 2, refresh_addr);
    check("loop", 0, loop_enabled);
    cmd(DSC_CMD_ACT, 2'h3, 13'h0033, 1'b0);
    check("banks", 0, bank_open);
    cmd(DSC_CMD_NOP, 2'h0, 13'h0000, 1'b1);
    check("self refresh", 0, self_refresh);
    check("loop", 1, loop_enabled);
    step(200);
    check("pending", 0, wq.size() + rq.size());
    print_verdict();
  end
endmodule
`default_nettype wire
